// >>> verilog/cpu_regs_pkg.sv
package cpu_regs_pkg;

  // Register widths
  localparam int NIB_W   = 4;
  localparam int PTR_W   = 2;
  localparam int PC_W    = 14;
  localparam int SP_W    = 10;
  localparam int RAM_AW  = 10;

  // RAM decode boundaries
  localparam logic [9:0] BANK_LO     = 10'h100;
  localparam logic [9:0] BANK_HI     = 10'h2cf;
  localparam logic [9:0] COMMON_HI   = 10'h0ff;
  localparam logic [9:0] STACK_LO    = 10'h3c0;
  localparam logic [9:0] BANK_SEL_AD = 10'h03f;

  // Software register offsets on the plain port
  localparam logic [9:0] OFS_BANK_SEL   = 10'h03f;
  localparam logic [9:0] OFS_IRQ0       = 10'h000;
  localparam logic [9:0] OFS_IRQ1       = 10'h001;
  localparam logic [9:0] OFS_IRQ2       = 10'h002;
  localparam logic [9:0] OFS_IRQ3       = 10'h003;
  localparam logic [9:0] OFS_BITREG     = 10'h020;
  localparam logic [9:0] OFS_PORT_MODE_A = 10'h004;
  localparam logic [9:0] OFS_PORT_MODE_B = 10'h005;
  localparam logic [9:0] OFS_TIMER_A_MODE = 10'h008;
  localparam logic [9:0] OFS_SERIAL_MODE = 10'h00c;
  localparam logic [9:0] OFS_LCD_CTRL   = 10'h01b;
  localparam logic [9:0] OFS_TONE_CTRL  = 10'h01d;
  localparam logic [9:0] OFS_EXTRA      = 10'h00c + 10'h018;
  localparam logic [9:0] OFS_STATUS     = 10'h3bf;
  localparam logic [9:0] OFS_TIMER_B_MODE = 10'h009;
  localparam logic [9:0] OFS_TIMER_C_MODE = 10'h00d;
  localparam logic [9:0] OFS_LCD_MODE     = 10'h01c;
  localparam logic [9:0] OFS_TONE_MODE    = 10'h01e;
  localparam logic [9:0] OFS_RELOAD_B_LO  = 10'h00a;
  localparam logic [9:0] OFS_RELOAD_B_HI  = 10'h00b;
  localparam logic [9:0] OFS_RELOAD_C_LO  = 10'h00e;
  localparam logic [9:0] OFS_RELOAD_C_HI  = 10'h00f;
  localparam logic [9:0] OFS_PORT_LATCH   = 10'h0d0;
  localparam logic [9:0] OFS_PORT_DRIVE   = 10'h0d8;

  // Stack pointer handling
  localparam logic [9:0] SP_RESET = 10'h3ff;
  localparam logic [9:0] SP_STEP  = 10'h004;
  localparam logic [3:0] SP_TOP   = 4'hf;

  // Bit positions in irq word 0
  localparam int GATE_BIT   = 0;
  localparam int REINIT_BIT = 1;

  // Reset values
  localparam logic [13:0] PC_RESET    = 14'h0000;
  localparam logic        BRANCH_RST  = 1'b1;
  localparam logic [3:0]  BANK_RESET  = 4'h0;
  localparam logic [3:0]  MODE_RESET  = 4'h0;
  localparam logic [3:0]  LATCH_RESET = 4'hf;
  localparam logic [3:0]  DRIVE_RESET = 4'h0;
  localparam logic [3:0]  IRQ0_RESET  = 4'h8;
  localparam logic [3:0]  IRQ12_RESET = 4'ha;
  localparam logic [3:0]  IRQ3_RESET  = 4'h2;
  localparam logic [7:0]  COUNT_RESET = 8'h00;
  localparam logic [10:0] PRE_S_RESET = 11'h000;
  localparam logic [7:0]  PRE_W_RESET = 8'h00;
  localparam logic [2:0]  OCT_RESET   = 3'h0;

  // Number of I/O ports
  localparam int NPORT = 4;

endpackage : cpu_regs_pkg

// >>> verilog/cpu_register_flags_reset.sv
`timescale 1ns/100ps
// Function
// - Accumulator and working register hold results
// - Bank selector picks RAM bank 100-2CF
// - Common areas ignore bank; selector at 03F
// - Indirect address from pointers; low addresses port
// - Two shadow pointers supplement mid and low
// - Overflow bit from ALU and set/clear/rotate
// - Interrupt pushes overflow; only interrupt return restores
// - Branch bit latches overflow, not-zero, bit test
// - Jump or invoke fetch forces branch bit one
// - Interrupt pushes branch bit; interrupt return restores
// - Fourteen-bit program pointer of current instruction
// - Stack index resets 3FF, steps by four
// - Upper four stack index bits fixed ones
// - Clearing reinit bit reloads stack index
// - Pins high impedance at power-on
// - Reset: pointer zero, branch one, bank zero
// - Reset: gate and pending clear, blocks set
// - Reset: latches one, drive enables zero
// - Reset clears mode, control, timer, prescaler registers
// - Reset clears four single-bit flag registers
// - Working registers and pointers left uninitialised
// - RAM contents survive reset
module cpu_register_flags_reset (
  input  wire logic        clk,          // System clock
  input  wire logic        rst,          // Asynchronous reset, high
  input  wire logic [9:0]  reg_addr,     // Register address
  input  wire logic [3:0]  reg_wdata,    // Register write data
  input  wire logic        reg_wr,       // Register write strobe
  input  wire logic        reg_rd,       // Register read strobe
  output logic      [3:0]  reg_rdata,    // Read data, cycle after strobe
  input  wire logic        acc_we,       // Load accumulator
  input  wire logic        work_we,      // Load working register
  input  wire logic [3:0]  alu_result,   // ALU result nibble
  input  wire logic        top_we,       // Load top pointer
  input  wire logic        mid_we,       // Load middle pointer
  input  wire logic        low_we,       // Load low pointer
  input  wire logic        smid_we,      // Load shadow middle pointer
  input  wire logic        slow_we,      // Load shadow low pointer
  input  wire logic        alu_ovf,      // ALU overflow this op
  input  wire logic        ovf_upd,      // Arithmetic op updates overflow
  input  wire logic        set_overflow_op,   // Set overflow
  input  wire logic        clear_overflow_op, // Clear overflow
  input  wire logic        rotate_op,    // Rotate left or right
  input  wire logic        rotate_out,   // Bit rotated into overflow
  input  wire logic        cond_upd,     // Arith/compare/test op
  input  wire logic        cond_val,     // Condition result
  input  wire logic        branch_fetch, // Jump or invoke fetched
  input  wire logic        irq_entry,    // Interrupt entry push
  input  wire logic        return_from_interrupt_op, // Restore flags
  input  wire logic        return_op,    // Plain return
  input  wire logic        pop_ovf,      // Overflow from stack
  input  wire logic        pop_cond,     // Branch bit from stack
  input  wire logic        push,         // Stack push
  input  wire logic        pop,          // Stack pop
  input  wire logic        pc_load,      // Load program pointer
  input  wire logic [13:0] pc_value,     // New program pointer
  input  wire logic        pc_step,      // Advance program pointer
  input  wire logic        irq_set_0,    // Pending event source 0
  output logic      [3:0]  acc,          // Accumulator
  output logic      [3:0]  work,         // Working register
  output logic      [9:0]  ram_addr_ind, // Indirect RAM address
  output logic      [3:0]  d_port_sel,   // Discrete port address
  output logic      [3:0]  shadow_mid_pointer, // Shadow middle pointer
  output logic      [3:0]  shadow_low_pointer, // Shadow low pointer
  output logic             overflow_bit, // Overflow flag
  output logic             branch_condition_bit, // Branch flag
  output logic      [1:0]  push_flags,   // Flags pushed on interrupt
  output logic      [13:0] program_pointer, // Program pointer
  output logic      [9:0]  stack_index,  // Stack index
  input  wire logic [9:0]  ram_addr,     // Any RAM access address
  output logic             ram_bank,     // Bank answering the access
  output logic      [15:0] port_out,     // Port pin outputs
  output logic      [15:0] port_oe       // Port pin output enables
);

  // State registers
  logic [3:0]  acc_q, work_q, mid_q, low_q, smid_q, slow_q;
  logic [1:0]  top_q;
  logic        ovf_q, cond_q;
  logic [13:0] pc_q;
  logic [5:0]  sp_lo_q;
  logic [3:0]  bank_q;
  logic [3:0]  irq_q [0:3];
  logic [3:0]  bitreg_q;
  logic [3:0]  mode_a_q, mode_b_q, tmode_q, smode_q, lcd_q, tone_q, extra_q;
  logic [3:0]  tmode_b_q, tmode_c_q, lcd_mode_q, tone_mode_q;
  logic [7:0]  tcount_b_q, tcount_c_q, reload_b_q, reload_c_q;
  logic [3:0]  latch_q [0:cpu_regs_pkg::NPORT-1];
  logic [3:0]  drive_q [0:cpu_regs_pkg::NPORT-1];
  logic [7:0]  tcount_q;
  logic [10:0] pre_s_q;
  logic [7:0]  pre_w_q;
  logic [2:0]  oct_q;
  logic [3:0]  rdata_q;

  logic        reinit_clr;
  logic [9:0]  sp_full;

  // Working data, never reset so software must load them
  always_ff @(posedge clk) begin
    if (acc_we) acc_q <= alu_result;
    if (work_we) work_q <= alu_result;
  end

  // Indirect and shadow pointers, likewise uninitialised
  always_ff @(posedge clk) begin
    if (top_we) top_q <= alu_result[1:0];
    if (mid_we) mid_q <= alu_result;
    if (low_we) low_q <= alu_result;
    if (smid_we) smid_q <= alu_result;
    if (slow_we) slow_q <= alu_result;
  end

  // Overflow flag; no reset value by design
  always_ff @(posedge clk) begin
    if (return_from_interrupt_op) begin
      ovf_q <= pop_ovf;
    end else if (set_overflow_op) begin
      ovf_q <= 1'b1;
    end else if (clear_overflow_op) begin
      ovf_q <= 1'b0;
    end else if (rotate_op) begin
      ovf_q <= rotate_out;
    end else if (ovf_upd) begin
      ovf_q <= alu_ovf;
    end
  end

  // Branch flag; fetch of a jump forces it back to one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cond_q <= cpu_regs_pkg::BRANCH_RST;
    end else if (return_from_interrupt_op) begin
      cond_q <= pop_cond;
    end else if (branch_fetch) begin
      cond_q <= 1'b1;
    end else if (cond_upd) begin
      cond_q <= cond_val;
    end
  end

  // Program pointer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_q <= cpu_regs_pkg::PC_RESET;
    end else if (pc_load) begin
      pc_q <= pc_value;
    end else if (pc_step) begin
      pc_q <= 14'(pc_q + 14'h0001);
    end
  end

  // Clearing the reinit bit through a write reloads the stack
  assign reinit_clr = reg_wr && (reg_addr == cpu_regs_pkg::OFS_IRQ0) &&
                      !reg_wdata[cpu_regs_pkg::REINIT_BIT];

  // Only low six bits are stored; top four are hardwired ones
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sp_lo_q <= cpu_regs_pkg::SP_RESET[5:0];
    end else if (reinit_clr) begin
      sp_lo_q <= cpu_regs_pkg::SP_RESET[5:0];
    end else if (push && !pop) begin
      sp_lo_q <= 6'(sp_lo_q - cpu_regs_pkg::SP_STEP[5:0]);
    end else if (pop && !push) begin
      sp_lo_q <= 6'(sp_lo_q + cpu_regs_pkg::SP_STEP[5:0]);
    end
  end
  assign sp_full = {cpu_regs_pkg::SP_TOP, sp_lo_q};

  // Bank selector and single-bit flag registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bank_q   <= cpu_regs_pkg::BANK_RESET;
      bitreg_q <= cpu_regs_pkg::MODE_RESET;
    end else if (reg_wr) begin
      if (reg_addr == cpu_regs_pkg::OFS_BANK_SEL) bank_q <= reg_wdata;
      if (reg_addr == cpu_regs_pkg::OFS_BITREG) bitreg_q <= reg_wdata;
    end
  end

  // Interrupt control words; pending bit 2 of word 0 set by hardware or by a software write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_q[0] <= cpu_regs_pkg::IRQ0_RESET;
      irq_q[1] <= cpu_regs_pkg::IRQ12_RESET;
      irq_q[2] <= cpu_regs_pkg::IRQ12_RESET;
      irq_q[3] <= cpu_regs_pkg::IRQ3_RESET;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (reg_wr && reg_addr == 10'(i)) irq_q[i] <= reg_wdata;
      end
      if (irq_entry) irq_q[0][cpu_regs_pkg::GATE_BIT] <= 1'b0;
      if (irq_set_0) irq_q[0][2] <= 1'b1; // Set beats clear
    end
  end

  // Mode, control, timer and prescaler state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_a_q <= cpu_regs_pkg::MODE_RESET;
      mode_b_q <= cpu_regs_pkg::MODE_RESET;
      tmode_q  <= cpu_regs_pkg::MODE_RESET;
      smode_q  <= cpu_regs_pkg::MODE_RESET;
      lcd_q    <= cpu_regs_pkg::MODE_RESET;
      tone_q   <= cpu_regs_pkg::MODE_RESET;
      extra_q  <= cpu_regs_pkg::MODE_RESET;
      tcount_q <= cpu_regs_pkg::COUNT_RESET;
      pre_s_q  <= cpu_regs_pkg::PRE_S_RESET;
      pre_w_q  <= cpu_regs_pkg::PRE_W_RESET;
      oct_q    <= cpu_regs_pkg::OCT_RESET;
    end else begin
      pre_s_q <= 11'(pre_s_q + 11'h001);
      pre_w_q <= 8'(pre_w_q + 8'h01);
      oct_q   <= 3'(oct_q + 3'h1);
      if (tmode_q != cpu_regs_pkg::MODE_RESET) tcount_q <= 8'(tcount_q + 8'h01);
      if (reg_wr) begin
        case (reg_addr)
          cpu_regs_pkg::OFS_PORT_MODE_A:  mode_a_q <= reg_wdata;
          cpu_regs_pkg::OFS_PORT_MODE_B:  mode_b_q <= reg_wdata;
          cpu_regs_pkg::OFS_TIMER_A_MODE: tmode_q  <= reg_wdata;
          cpu_regs_pkg::OFS_SERIAL_MODE:  smode_q  <= reg_wdata;
          cpu_regs_pkg::OFS_LCD_CTRL:     lcd_q    <= reg_wdata;
          cpu_regs_pkg::OFS_TONE_CTRL:    tone_q   <= reg_wdata;
          cpu_regs_pkg::OFS_EXTRA:        extra_q  <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // Timer B/C, display and tone mode state; reloads written a nibble at a time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tmode_b_q   <= cpu_regs_pkg::MODE_RESET;
      tmode_c_q   <= cpu_regs_pkg::MODE_RESET;
      lcd_mode_q  <= cpu_regs_pkg::MODE_RESET;
      tone_mode_q <= cpu_regs_pkg::MODE_RESET;
      reload_b_q  <= cpu_regs_pkg::COUNT_RESET;
      reload_c_q  <= cpu_regs_pkg::COUNT_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        cpu_regs_pkg::OFS_TIMER_B_MODE: tmode_b_q       <= reg_wdata;
        cpu_regs_pkg::OFS_TIMER_C_MODE: tmode_c_q       <= reg_wdata;
        cpu_regs_pkg::OFS_LCD_MODE:     lcd_mode_q      <= reg_wdata;
        cpu_regs_pkg::OFS_TONE_MODE:    tone_mode_q     <= reg_wdata;
        cpu_regs_pkg::OFS_RELOAD_B_LO:  reload_b_q[3:0] <= reg_wdata;
        cpu_regs_pkg::OFS_RELOAD_B_HI:  reload_b_q[7:4] <= reg_wdata;
        cpu_regs_pkg::OFS_RELOAD_C_LO:  reload_c_q[3:0] <= reg_wdata;
        cpu_regs_pkg::OFS_RELOAD_C_HI:  reload_c_q[7:4] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Timers B and C count while enabled; wrap reloads so a half-written reload may load
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tcount_b_q <= cpu_regs_pkg::COUNT_RESET;
      tcount_c_q <= cpu_regs_pkg::COUNT_RESET;
    end else begin
      if (tmode_b_q != cpu_regs_pkg::MODE_RESET) begin
        tcount_b_q <= (tcount_b_q == 8'hff) ? reload_b_q : 8'(tcount_b_q + 8'h01);
      end
      if (tmode_c_q != cpu_regs_pkg::MODE_RESET) begin
        tcount_c_q <= (tcount_c_q == 8'hff) ? reload_c_q : 8'(tcount_c_q + 8'h01);
      end
    end
  end

  // Port latches and drive enables, one pair per port
  generate
    for (genvar p = 0; p < cpu_regs_pkg::NPORT; p++) begin : g_port
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          latch_q[p] <= cpu_regs_pkg::LATCH_RESET;
          drive_q[p] <= cpu_regs_pkg::DRIVE_RESET;
        end else if (reg_wr && reg_addr == 10'(cpu_regs_pkg::OFS_PORT_LATCH + 10'(p))) begin
          latch_q[p] <= reg_wdata;
        end else if (reg_wr && reg_addr == 10'(cpu_regs_pkg::OFS_PORT_DRIVE + 10'(p))) begin
          drive_q[p] <= reg_wdata;
        end
      end
      assign port_out[4*p +: 4] = latch_q[p];
      assign port_oe[4*p +: 4]  = drive_q[p];
    end
  endgenerate

  // Read data, registered one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 4'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        cpu_regs_pkg::OFS_BANK_SEL: rdata_q <= bank_q;
        cpu_regs_pkg::OFS_IRQ0:     rdata_q <= irq_q[0];
        cpu_regs_pkg::OFS_IRQ1:     rdata_q <= irq_q[1];
        cpu_regs_pkg::OFS_IRQ2:     rdata_q <= irq_q[2];
        cpu_regs_pkg::OFS_IRQ3:     rdata_q <= irq_q[3];
        cpu_regs_pkg::OFS_BITREG:   rdata_q <= bitreg_q;
        cpu_regs_pkg::OFS_PORT_MODE_A: rdata_q <= mode_a_q;
        cpu_regs_pkg::OFS_PORT_MODE_B: rdata_q <= mode_b_q;
        cpu_regs_pkg::OFS_TIMER_A_MODE: rdata_q <= tmode_q;
        cpu_regs_pkg::OFS_TIMER_B_MODE: rdata_q <= tmode_b_q;
        cpu_regs_pkg::OFS_TIMER_C_MODE: rdata_q <= tmode_c_q;
        cpu_regs_pkg::OFS_SERIAL_MODE: rdata_q <= smode_q;
        cpu_regs_pkg::OFS_LCD_CTRL: rdata_q <= lcd_q;
        cpu_regs_pkg::OFS_LCD_MODE: rdata_q <= lcd_mode_q;
        cpu_regs_pkg::OFS_TONE_CTRL: rdata_q <= tone_q;
        cpu_regs_pkg::OFS_TONE_MODE: rdata_q <= tone_mode_q;
        cpu_regs_pkg::OFS_EXTRA:    rdata_q <= extra_q;
        cpu_regs_pkg::OFS_RELOAD_B_LO: rdata_q <= reload_b_q[3:0];
        cpu_regs_pkg::OFS_RELOAD_B_HI: rdata_q <= reload_b_q[7:4];
        cpu_regs_pkg::OFS_RELOAD_C_LO: rdata_q <= reload_c_q[3:0];
        cpu_regs_pkg::OFS_RELOAD_C_HI: rdata_q <= reload_c_q[7:4];
        cpu_regs_pkg::OFS_STATUS:   rdata_q <= {2'h0, ovf_q, cond_q};
        // Port latches and drive enables sit in two runs of NPORT words
        default: begin
          rdata_q <= 4'h0;
          for (int p = 0; p < cpu_regs_pkg::NPORT; p++) begin
            if (reg_addr == 10'(cpu_regs_pkg::OFS_PORT_LATCH + 10'(p))) rdata_q <= latch_q[p];
            if (reg_addr == 10'(cpu_regs_pkg::OFS_PORT_DRIVE + 10'(p))) rdata_q <= drive_q[p];
          end
        end
      endcase
    end else begin
      rdata_q <= 4'h0;
    end
  end

  // Outputs; RAM array lives outside and has no reset
  assign reg_rdata            = rdata_q;
  assign acc                  = acc_q;
  assign work                 = work_q;
  assign ram_addr_ind         = {top_q, mid_q, low_q};
  assign d_port_sel           = low_q;
  assign shadow_mid_pointer   = smid_q;
  assign shadow_low_pointer   = slow_q;
  assign overflow_bit         = ovf_q;
  assign branch_condition_bit = cond_q;
  assign push_flags           = {ovf_q, cond_q};
  assign program_pointer      = pc_q;
  assign stack_index          = sp_full;
  // Banked window only; common and stack areas always bank 0
  assign ram_bank = (ram_addr >= cpu_regs_pkg::BANK_LO) &&
                    (ram_addr <= cpu_regs_pkg::BANK_HI) && bank_q[0];

endmodule : cpu_register_flags_reset

// >>> dv/cpu_register_flags_reset_properties.sv
`timescale 1ns/100ps
module cpu_regs_checker (
  input wire logic        clk,                      // System clock
  input wire logic        rst,                      // Async reset
  input wire logic        reg_wr,                   // Write strobe
  input wire logic        push,                     // Stack push
  input wire logic        pop,                      // Stack pop
  input wire logic [9:0]  stack_index,              // Stack index
  input wire logic        branch_fetch,             // Jump fetched
  input wire logic        return_from_interrupt_op, // Flag restore
  input wire logic        pop_ovf,                  // Popped overflow
  input wire logic        pop_cond,                 // Popped branch bit
  input wire logic        branch_condition_bit,     // Branch flag
  input wire logic        cond_upd,                 // Condition update
  input wire logic        cond_val,                 // Condition value
  input wire logic        set_overflow_op,          // Set overflow
  input wire logic        clear_overflow_op,        // Clear overflow
  input wire logic        overflow_bit,             // Overflow flag
  input wire logic [9:0]  ram_addr,                 // RAM address
  input wire logic        ram_bank                  // Bank answering
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Step checks skip the ends of the ring, where wrap behaviour is open
  stack_top_a: assert property (stack_index[9:6] == 4'hf)
    else $error("stack index top bits not all ones");
  push_step_a: assert property ((push && !pop && !reg_wr && stack_index[5:2] != 4'h0)
    |=> stack_index == $past(stack_index) - 10'h004) else $error("push did not step down by four");
  pop_step_a: assert property ((pop && !push && !reg_wr && stack_index[5:2] != 4'hf)
    |=> stack_index == $past(stack_index) + 10'h004) else $error("pop did not step up by four");
  fetch_force_a: assert property ((branch_fetch && !return_from_interrupt_op) |=> branch_condition_bit)
    else $error("branch bit not forced after fetch");
  cond_latch_a: assert property ((cond_upd && !branch_fetch && !return_from_interrupt_op)
    |=> branch_condition_bit == $past(cond_val)) else $error("branch bit did not latch condition");
  ovf_set_a: assert property ((set_overflow_op && !return_from_interrupt_op) |=> overflow_bit)
    else $error("overflow not set");
  ovf_clear_a: assert property ((clear_overflow_op && !set_overflow_op && !return_from_interrupt_op)
    |=> !overflow_bit) else $error("overflow not cleared");
  rti_restore_a: assert property (return_from_interrupt_op |=>
    (overflow_bit == $past(pop_ovf)) && (branch_condition_bit == $past(pop_cond)))
    else $error("interrupt return did not restore flags");
  bank_range_a: assert property (ram_bank |-> (ram_addr >= 10'h100 && ram_addr <= 10'h2cf))
    else $error("bank asserted outside banked range");
endmodule : cpu_regs_checker

bind cpu_register_flags_reset cpu_regs_checker cpu_regs_checker_inst (.*);

// >>> dv/tb_cpu_register_flags_reset.sv
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_cpu_register_flags_reset;
  logic        clk = 1'b0, rst = 1'b1;
  logic [9:0]  reg_addr, ram_addr, ram_addr_ind, stack_index;
  logic [3:0]  reg_wdata, alu_result, reg_rdata, acc, work, d_port_sel;
  logic [3:0]  shadow_mid_pointer, shadow_low_pointer;
  logic [13:0] pc_value, program_pointer;
  logic [15:0] port_out, port_oe;
  logic [1:0]  push_flags;
  logic        reg_wr, reg_rd, acc_we, work_we, top_we, mid_we, low_we, smid_we, slow_we;
  logic        alu_ovf, ovf_upd, set_overflow_op, clear_overflow_op, rotate_op, rotate_out;
  logic        cond_upd, cond_val, branch_fetch, irq_entry, return_from_interrupt_op, return_op;
  logic        pop_ovf, pop_cond, push, pop, pc_load, pc_step, irq_set_0;
  logic        overflow_bit, branch_condition_bit, ram_bank;
  int          failures = 0, checks = 0;
  logic [9:0]  ra [24];
  logic [3:0]  re [24];

  cpu_register_flags_reset cpu_register_flags_reset_inst (.*);

  // Free-running clock at 50 MHz
  always #10 clk = ~clk;

  task automatic wrap_up;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  // Lets the taking edge pass, drops every strobe, then settles
  task automatic idle;
    @(posedge clk);
    {acc_we, work_we, top_we, mid_we, low_we, smid_we, slow_we, ovf_upd, set_overflow_op, clear_overflow_op,
     rotate_op, cond_upd, branch_fetch, irq_entry, return_from_interrupt_op, return_op, push, pop,
     pc_load, pc_step, irq_set_0, reg_wr, reg_rd} <= '0;
    #1;
  endtask : idle

  task automatic wr(input logic [9:0] a, input logic [3:0] d);
    @(posedge clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
    idle;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [9:0] a, input logic [3:0] e);
    @(posedge clk) begin reg_rd <= 1'b1; reg_addr <= a; end
    idle;
    `CHK(reg_rdata, e)
  endtask : rd

  // Hang guard; nothing here waits on the design
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    wrap_up;
  end

  initial begin
    {acc_we, work_we, top_we, mid_we, low_we, smid_we, slow_we, ovf_upd, set_overflow_op, clear_overflow_op,
     rotate_op, cond_upd, branch_fetch, irq_entry, return_from_interrupt_op, return_op, push, pop,
     pc_load, pc_step, irq_set_0, reg_wr, reg_rd, alu_ovf, rotate_out, cond_val, pop_ovf, pop_cond} = '0;
    {reg_addr, ram_addr, reg_wdata, alu_result, pc_value} = '0;
    ra = '{10'h000, 10'h001, 10'h002, 10'h003, 10'h020, 10'h004, 10'h005, 10'h008, 10'h00c,
           10'h01b, 10'h01d, 10'h024, 10'h03f, 10'h0d0, 10'h0d3, 10'h0d8, 10'h0db, 10'h009,
           10'h00d, 10'h01c, 10'h01e, 10'h00a, 10'h00f, 10'h3c5};
    re = '{4'h8, 4'ha, 4'ha, 4'h2, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0,
           4'h0, 4'h0, 4'h0, 4'h0, 4'hf, 4'hf, 4'h0, 4'h0, 4'h0,
           4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
    repeat (8) @(posedge clk);
    #1;
    // Values held while reset is still high
    `CHK(program_pointer, 14'h0000)
    `CHK(branch_condition_bit, 1'b1)
    `CHK(stack_index, 10'h3ff)
    `CHK(port_oe, 16'h0000)
    `CHK(port_out, 16'hffff)
    @(posedge clk) rst <= 1'b0;
    // Reset image of the software registers, unmapped place last
    for (int i = 0; i < 24; i++) rd(ra[i], re[i]);
    // Bank decode at the edges of the banked window
    @(posedge clk) ram_addr <= 10'h150;
    #1 `CHK(ram_bank, 1'b0)
    wr(10'h03f, 4'h1);
    rd(10'h03f, 4'h1);
    `CHK(ram_bank, 1'b1)
    @(posedge clk) ram_addr <= 10'h2cf;
    #1 `CHK(ram_bank, 1'b1)
    @(posedge clk) ram_addr <= 10'h2d0;
    #1 `CHK(ram_bank, 1'b0)
    @(posedge clk) ram_addr <= 10'h0ff;
    #1 `CHK(ram_bank, 1'b0)
    @(posedge clk) ram_addr <= 10'h3c5;
    #1 `CHK(ram_bank, 1'b0)
    // Working registers and pointers
    @(posedge clk) begin acc_we <= 1'b1; alu_result <= 4'h5; end
    idle; `CHK(acc, 4'h5)
    @(posedge clk) begin work_we <= 1'b1; top_we <= 1'b1; smid_we <= 1'b1; alu_result <= 4'ha; end
    idle; `CHK(work, 4'ha)
    `CHK(shadow_mid_pointer, 4'ha)
    @(posedge clk) begin mid_we <= 1'b1; low_we <= 1'b1; slow_we <= 1'b1; alu_result <= 4'hc; end
    idle; `CHK(ram_addr_ind, 10'h2cc)
    `CHK(d_port_sel, 4'hc)
    `CHK(shadow_low_pointer, 4'hc)
    // Overflow flag sources one after another
    @(posedge clk) set_overflow_op <= 1'b1;
    idle; `CHK(overflow_bit, 1'b1)
    @(posedge clk) clear_overflow_op <= 1'b1;
    idle; `CHK(overflow_bit, 1'b0)
    @(posedge clk) begin rotate_op <= 1'b1; rotate_out <= 1'b1; end
    idle; `CHK(overflow_bit, 1'b1)
    @(posedge clk) begin ovf_upd <= 1'b1; alu_ovf <= 1'b0; cond_upd <= 1'b1; cond_val <= 1'b0; end
    idle; `CHK(overflow_bit, 1'b0)
    `CHK(branch_condition_bit, 1'b0)
    // Plain return leaves both flags alone
    @(posedge clk) begin return_op <= 1'b1; pop_ovf <= 1'b1; pop_cond <= 1'b1; end
    idle; `CHK({overflow_bit, branch_condition_bit}, 2'b00)
    @(posedge clk) irq_entry <= 1'b1;
    idle; `CHK(push_flags, 2'b00)
    @(posedge clk) return_from_interrupt_op <= 1'b1;
    idle; `CHK({overflow_bit, branch_condition_bit}, 2'b11)
    @(posedge clk) begin cond_upd <= 1'b1; cond_val <= 1'b0; end
    idle;
    @(posedge clk) branch_fetch <= 1'b1;
    idle; `CHK(branch_condition_bit, 1'b1)
    // Program pointer load and step
    @(posedge clk) begin pc_load <= 1'b1; pc_value <= 14'h3abc; end
    idle; `CHK(program_pointer, 14'h3abc)
    @(posedge clk) pc_step <= 1'b1;
    idle; `CHK(program_pointer, 14'h3abd)
    // Stack steps, then reload by clearing the reinit bit
    @(posedge clk) push <= 1'b1;
    @(posedge clk) push <= 1'b1;
    idle; `CHK(stack_index, 10'h3f7)
    @(posedge clk) pop <= 1'b1;
    idle; `CHK(stack_index, 10'h3fb)
    @(posedge clk) push <= 1'b1;
    idle;
    wr(10'h000, 4'h8);
    `CHK(stack_index, 10'h3ff)
    @(posedge clk) irq_set_0 <= 1'b1;
    idle;
    rd(10'h000, 4'hc);
    // Second reset in mid-run restores the reset image
    @(posedge clk) push <= 1'b1;
    idle;
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK(stack_index, 10'h3ff)
    `CHK(program_pointer, 14'h0000)
    @(posedge clk) rst <= 1'b0;
    rd(10'h03f, 4'h0);
    rd(10'h000, 4'h8);
    wrap_up;
  end
endmodule : tb_cpu_register_flags_reset
